//--- hdl/car_pkg.sv
// package: constants and types of the alarm and autorange controller
package car_pkg;

	// ========================================
	// widths and ppm figures
	localparam int          CONC_W        = 18;
	localparam logic [17:0] CONC_MAX      = 18'h3_d090;
	localparam logic [17:0] LOW_DEF       = 18'h0064;
	localparam logic [17:0] MID_DEF       = 18'h03e8;
	localparam logic [17:0] TOP_DEF       = 18'h2710;
	localparam logic [17:0] PERCENT_ABOVE = 18'h2710;
	localparam logic [17:0] AIR_FULL      = 18'h3_d090;
	localparam logic [6:0]  DOWN_PCT      = 7'h55;
	localparam logic [6:0]  FULL_PCT      = 7'h64;

	// ========================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_AL1    = 8'h04;
	localparam logic [7:0] OFS_AL2    = 8'h08;
	localparam logic [7:0] OFS_RLOW   = 8'h0c;
	localparam logic [7:0] OFS_RMID   = 8'h10;
	localparam logic [7:0] OFS_RTOP   = 8'h14;
	localparam logic [7:0] OFS_CONC   = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;

	// ========================================
	// field positions
	localparam int CTRL_STBY = 0;
	localparam int CTRL_AIR  = 1;
	localparam int CTRL_MODE = 2;
	localparam int CTRL_MENU = 4;
	localparam int CFG_DIR   = 24;
	localparam int CFG_DFT   = 25;
	localparam int CFG_FS    = 26;
	localparam int CFG_LTCH  = 27;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] AL_RST   = 32'h0000_0000;

	// ========================================
	// timing
	localparam int MENU_TIMEOUT_S = 270;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int SEC_CYCLES     = 1000000000 / CLK_PERIOD_NS;

	// ========================================
	// types
	typedef enum logic [1:0] {
		CAR_ANALYZE = 2'b01,
		CAR_MENU    = 2'b10
	} car_screen_t;

	typedef struct packed {
		logic        latch;
		logic        failsafe;
		logic        defeat;
		logic        dirHigh;
		logic [17:0] setpoint;
	} car_alarm_cfg_t;

	typedef struct packed {
		logic [1:0]  rangeId;
		logic [17:0] fullScale;
		logic [17:0] level;
	} car_analog_t;

endpackage

//--- hdl/car_ctrl.sv
// module: concentration alarms, analog range selection, standby, menu
// Behaviour
// - high alarm trips above setpoint
// - low alarm trips below setpoint
// - two alarms, independent direction each
// - failsafe relay de-energized during alarm
// - non-failsafe relay energized during alarm
// - latching alarm holds until explicit reset
// - non-latching alarm follows condition
// - defeat suppresses alarm activation
// - defeat on then off clears latch
// - latch off then on clears latch
// - five settings per alarm
// - three ranges, defaults 100/1000/10000 ppm
// - autorange up when above limit
// - autorange down below 85% lower
// - range change updates output and id
// - fixed range clamps at full scale
// - readout keeps full precision always
// - air calibration uses fixed 0-25%
// - range limits must strictly increase
// - ppm to 250000, percent above 10000
// - standby blanks displays and outputs
// - menu idle timeout returns to analysis
// - standby exit clears cell failure
`timescale 1ns/1ps
`default_nettype none
module car_ctrl
	import car_pkg::*;
#(
	parameter int SEC_TICK = car_pkg::SEC_CYCLES
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// ahb-lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// measurement processor
	input  wire logic                 sampleValid,
	input  wire logic [17:0]          sampleConc,
	input  wire logic                 cellFailEvt,
	// front panel key pin
	input  wire logic                 keyPin,
	// relays, analog stage, readout
	output logic [1:0]                relayEnergize,
	output car_pkg::car_analog_t      analogOut,
	output logic [17:0]               readoutConc,
	output logic                      readoutPercent,
	output logic                      readoutBlank,
	output logic                      cellFail,
	output logic                      menuActive
);
	import car_pkg::*;

	// the menu second counter needs at least two cycles per tick
	if (SEC_TICK < 2) begin : gBadTick
		$error("SEC_TICK too small");
	end

	// ========================================
	// ahb-lite slave
	logic        wrPend_q;
	logic [7:0]  wrAddr_q;
	logic [31:0] ctrl_q;
	logic [31:0] alCfg_q [2];
	logic [17:0] limit_q [3];
	logic [17:0] conc_q;
	logic        reject_q;
	logic [31:0] status;
	logic [31:0] rdMux;
	logic        addrPh;

	assign addrPh    = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			wrPend_q <= addrPh && hwrite;
			wrAddr_q <= {haddr[7:2], 2'b00};
		end
	end

	always_comb begin
		case ({haddr[7:2], 2'b00})
			OFS_CTRL:   rdMux = ctrl_q;
			OFS_AL1:    rdMux = alCfg_q[0];
			OFS_AL2:    rdMux = alCfg_q[1];
			OFS_RLOW:   rdMux = {14'h0000, limit_q[0]};
			OFS_RMID:   rdMux = {14'h0000, limit_q[1]};
			OFS_RTOP:   rdMux = {14'h0000, limit_q[2]};
			OFS_CONC:   rdMux = {14'h0000, conc_q};
			OFS_STATUS: rdMux = status;
			default:    rdMux = 32'h0000_0000;
		endcase
	end

	// read data is captured in the address phase; a write directly
	// before it to the same word is not forwarded
	always_ff @(posedge clk) begin
		if (sys_rst)
			hrdata <= 32'h0000_0000;
		else if (addrPh && !hwrite)
			hrdata <= rdMux;
	end

	// ========================================
	// configuration registers
	logic        wrCtrl;
	logic [1:0]  wrAl;
	logic [2:0]  wrLim;
	logic [17:0] cand [3];
	logic        candOk;

	assign wrCtrl = wrPend_q && (wrAddr_q == OFS_CTRL);
	assign wrAl   = {wrPend_q && (wrAddr_q == OFS_AL2),
	                 wrPend_q && (wrAddr_q == OFS_AL1)};
	assign wrLim  = {wrPend_q && (wrAddr_q == OFS_RTOP),
	                 wrPend_q && (wrAddr_q == OFS_RMID),
	                 wrPend_q && (wrAddr_q == OFS_RLOW)};

	always_comb begin
		for (int i = 0; i < 3; i++)
			cand[i] = wrLim[i] ? hwdata[17:0] : limit_q[i];
		candOk = (cand[0] != 18'h0_0000) && (cand[0] < cand[1]) &&
		         (cand[1] < cand[2]) && (cand[2] <= CONC_MAX);
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			ctrl_q <= CTRL_RST;
		else if (wrCtrl)
			ctrl_q <= {27'h000_0000, hwdata[4:0]};
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			limit_q[0] <= LOW_DEF;
			limit_q[1] <= MID_DEF;
			limit_q[2] <= TOP_DEF;
			reject_q   <= 1'b0;
		end else if (|wrLim) begin
			reject_q <= !candOk;
			if (candOk) begin
				for (int i = 0; i < 3; i++)
					limit_q[i] <= cand[i];
			end
		end
	end

	// ========================================
	// sample capture
	always_ff @(posedge clk) begin
		if (sys_rst)
			conc_q <= 18'h0_0000;
		else if (sampleValid)
			conc_q <= sampleConc;
	end

	logic stby;
	logic stbyPrev_q;
	assign stby = ctrl_q[CTRL_STBY];

	assign readoutConc    = conc_q;
	assign readoutPercent = !stby && (conc_q > PERCENT_ABOVE);
	assign readoutBlank   = stby;

	// ========================================
	// concentration alarms
	logic [1:0] active_q;
	logic [1:0] cond_q;
	logic [1:0] dftPrev_q;
	logic [1:0] ltchPrev_q;
	car_alarm_cfg_t cfg [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gAlarm
			logic trip;
			assign cfg[g] = {alCfg_q[g][CFG_LTCH], alCfg_q[g][CFG_FS],
			                 alCfg_q[g][CFG_DFT], alCfg_q[g][CFG_DIR],
			                 alCfg_q[g][17:0]};
			assign trip = cfg[g].dirHigh ?
			              (sampleConc > cfg[g].setpoint) :
			              (sampleConc < cfg[g].setpoint);

			always_ff @(posedge clk) begin
				if (sys_rst)
					alCfg_q[g] <= AL_RST;
				else if (wrAl[g])
					alCfg_q[g] <= {4'h0, hwdata[27:24], 6'h00, hwdata[17:0]};
			end

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					cond_q[g]     <= 1'b0;
					active_q[g]   <= 1'b0;
					dftPrev_q[g]  <= 1'b0;
					ltchPrev_q[g] <= 1'b0;
				end else begin
					dftPrev_q[g]  <= cfg[g].defeat;
					ltchPrev_q[g] <= cfg[g].latch;
					if (sampleValid)
						cond_q[g] <= trip;
					if (cfg[g].defeat)
						active_q[g] <= 1'b0;
					else if (cfg[g].latch && !ltchPrev_q[g])
						active_q[g] <= 1'b0;
					else if (cfg[g].latch)
						active_q[g] <= active_q[g] || cond_q[g];
					else
						active_q[g] <= cond_q[g];
				end
			end

			assign relayEnergize[g] = !stby &&
			       (cfg[g].failsafe ? !active_q[g] : active_q[g]);
		end
	endgenerate

	// ========================================
	// range selection
	logic [1:0]  rangeSel_q;
	logic [1:0]  mode;
	logic [24:0] concScaled;
	logic [24:0] lowerScaled;
	logic [17:0] fullSel;

	assign mode        = ctrl_q[CTRL_MODE +: 2];
	assign concScaled  = sampleConc * FULL_PCT;
	assign lowerScaled = limit_q[rangeSel_q - 2'd1] * DOWN_PCT;

	// one step per sample; a jump across two ranges settles in two
	always_ff @(posedge clk) begin
		if (sys_rst)
			rangeSel_q <= 2'd0;
		else if (mode != 2'd0)
			rangeSel_q <= mode - 2'd1;
		else if (sampleValid) begin
			if (rangeSel_q < 2'd2 && sampleConc > limit_q[rangeSel_q])
				rangeSel_q <= rangeSel_q + 2'd1;
			else if (rangeSel_q > 2'd0 && concScaled < lowerScaled)
				rangeSel_q <= rangeSel_q - 2'd1;
		end
	end

	assign fullSel = ctrl_q[CTRL_AIR] ? AIR_FULL : limit_q[rangeSel_q];

	always_ff @(posedge clk) begin
		if (sys_rst || stby)
			analogOut <= '0;
		else begin
			analogOut.fullScale <= fullSel;
			analogOut.rangeId   <= ctrl_q[CTRL_AIR] ? 2'd3 : rangeSel_q;
			analogOut.level     <= (conc_q > fullSel) ? fullSel : conc_q;
		end
	end

	// ========================================
	// cell failure flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cellFail   <= 1'b0;
			stbyPrev_q <= 1'b0;
		end else begin
			stbyPrev_q <= stby;
			if (cellFailEvt)
				cellFail <= 1'b1;
			else if (stbyPrev_q && !stby)
				cellFail <= 1'b0;
		end
	end

	// ========================================
	// menu timeout
	logic [1:0]  keySync_q;
	logic        keyPrev_q;
	logic        keyEdge;
	logic [31:0] tick_q;
	logic [8:0]  secs_q;
	car_screen_t screen_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			keySync_q <= 2'b00;
			keyPrev_q <= 1'b0;
		end else begin
			keySync_q <= {keySync_q[0], keyPin};
			keyPrev_q <= keySync_q[1];
		end
	end
	assign keyEdge = keySync_q[1] && !keyPrev_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			screen_q <= CAR_ANALYZE;
			tick_q   <= 32'h0000_0000;
			secs_q   <= 9'h000;
		end else begin
			case (screen_q)
				CAR_ANALYZE: begin
					tick_q <= 32'h0000_0000;
					secs_q <= 9'h000;
					if (wrCtrl && hwdata[CTRL_MENU])
						screen_q <= CAR_MENU;
				end
				CAR_MENU: begin
					if (keyEdge || wrCtrl) begin
						tick_q <= 32'h0000_0000;
						secs_q <= 9'h000;
					end else if (tick_q == 32'(SEC_TICK - 1)) begin
						tick_q <= 32'h0000_0000;
						secs_q <= secs_q + 9'h001;
					end else
						tick_q <= tick_q + 32'h0000_0001;
					if (secs_q == 9'(MENU_TIMEOUT_S))
						screen_q <= CAR_ANALYZE;
					else if (wrCtrl && !hwdata[CTRL_MENU])
						screen_q <= CAR_ANALYZE;
				end
				default: screen_q <= CAR_ANALYZE;
			endcase
		end
	end
	assign menuActive = (screen_q == CAR_MENU);

	assign status = {20'h0_0000, menuActive, cellFail, reject_q,
	                 readoutPercent, analogOut.rangeId, relayEnergize,
	                 active_q, cond_q};

	// ========================================
	// assertions
	property p_high_trip;
		@(posedge clk) disable iff (sys_rst)
		sampleValid && cfg[0].dirHigh && sampleConc > cfg[0].setpoint
		|=> cond_q[0];
	endproperty
	a_high_trip: assert property (p_high_trip) else $error("high trip");

	property p_low_trip;
		@(posedge clk) disable iff (sys_rst)
		sampleValid && !cfg[1].dirHigh && sampleConc < cfg[1].setpoint
		|=> cond_q[1];
	endproperty
	a_low_trip: assert property (p_low_trip) else $error("low trip");

	property p_failsafe;
		@(posedge clk) disable iff (sys_rst)
		!stby && cfg[0].failsafe |-> relayEnergize[0] == !active_q[0];
	endproperty
	a_failsafe: assert property (p_failsafe) else $error("failsafe");

	property p_nonfs;
		@(posedge clk) disable iff (sys_rst)
		!stby && !cfg[1].failsafe |-> relayEnergize[1] == active_q[1];
	endproperty
	a_nonfs: assert property (p_nonfs) else $error("non-failsafe");

	property p_latch_hold;
		@(posedge clk) disable iff (sys_rst)
		active_q[0] && cfg[0].latch && $stable(cfg[0]) && !cfg[0].defeat
		|=> active_q[0];
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch");

	property p_nonlatch;
		@(posedge clk) disable iff (sys_rst)
		!cfg[1].latch && !cfg[1].defeat |=> active_q[1] == $past(cond_q[1]);
	endproperty
	a_nonlatch: assert property (p_nonlatch) else $error("non-latch");

	property p_defeat;
		@(posedge clk) disable iff (sys_rst)
		cfg[0].defeat |=> !active_q[0];
	endproperty
	a_defeat: assert property (p_defeat) else $error("defeat");

	property p_range_up;
		@(posedge clk) disable iff (sys_rst)
		mode == 2'd0 && sampleValid && rangeSel_q == 2'd0 &&
		sampleConc > limit_q[0] |=> rangeSel_q == 2'd1;
	endproperty
	a_range_up: assert property (p_range_up) else $error("range up");

	property p_clamp;
		@(posedge clk) disable iff (sys_rst)
		!stby |=> analogOut.level <= analogOut.fullScale;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp");

	property p_order;
		@(posedge clk) disable iff (sys_rst)
		limit_q[0] < limit_q[1] && limit_q[1] < limit_q[2];
	endproperty
	a_order: assert property (p_order) else $error("range order");

	property p_standby;
		@(posedge clk) disable iff (sys_rst)
		stby && $past(stby) |-> relayEnergize == 2'b00 && analogOut == '0;
	endproperty
	a_standby: assert property (p_standby) else $error("standby");

	property p_cell_clear;
		@(posedge clk) disable iff (sys_rst)
		stbyPrev_q && !stby && !cellFailEvt |=> !cellFail;
	endproperty
	a_cell_clear: assert property (p_cell_clear) else $error("cell");

	c_latched: cover property (@(posedge clk) active_q[0] && cfg[0].latch);
	c_range_top: cover property (@(posedge clk) rangeSel_q == 2'd2);
	c_reject: cover property (@(posedge clk) reject_q);
	c_timeout: cover property (@(posedge clk)
		menuActive ##1 !menuActive);

endmodule
`default_nettype wire

//--- test/car_out_model.sv
// partner: relay contacts and analog output stage behind the controller
`timescale 1ns/1ps
`default_nettype none
module car_out_model
	import car_pkg::*;
(
	// clock
	input  wire logic                 clk,
	// from the controller
	input  wire logic [1:0]           relayEnergize,
	input  wire car_pkg::car_analog_t analogOut,
	// contacts and output in percent of range
	output logic [1:0]                contactMade,
	output logic [6:0]                outPct
);
	// ========================================
	// contacts
	// armature travel: contacts follow the coil one cycle late
	always_ff @(posedge clk) begin
		contactMade <= relayEnergize;
	end

	// ========================================
	// analog stage
	// zero span shows zero, the stage has nothing to scale against
	always_comb begin
		outPct = 7'h00;
		if (analogOut.fullScale != 18'h0_0000) begin
			outPct = 7'(({14'h0000, analogOut.level} * 32'h0000_0064)
				/ {14'h0000, analogOut.fullScale});
		end
	end
endmodule
`default_nettype wire

//--- test/car_ctrl_bench.sv
// bench: alarm, range, standby and menu checks of the controller
`timescale 1ns/1ps
`default_nettype none
module car_ctrl_bench;
	import car_pkg::*;
	// ========================================
	// signals
	typedef struct {int k; logic [31:0] v;} car_exp_t;
	logic        clk, sysRst, hsel, hwrite, hreadyout, hresp;
	logic        sampleValid, cellFailEvt, keyPin, menuActive;
	logic        readoutPercent, readoutBlank, cellFail;
	logic [1:0]  htrans, relayEnergize, contactMade;
	logic [2:0]  hsize;
	logic [6:0]  outPct;
	logic [17:0] sampleConc, readoutConc, rv;
	logic [31:0] haddr, hwdata, hrdata, rdVal, tbVal, act;
	car_analog_t analogOut;
	car_exp_t    expQ[$];
	car_exp_t    curE;
	event        chkEv;
	int          n_fail = 0;
	int          n_compared = 0;
	int          seed = 42;
	int          cnt;

	car_ctrl #(.SEC_TICK(4)) u_car_ctrl (.clk(clk), .sys_rst(sysRst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sampleValid(sampleValid), .sampleConc(sampleConc),
		.cellFailEvt(cellFailEvt), .keyPin(keyPin),
		.relayEnergize(relayEnergize), .analogOut(analogOut),
		.readoutConc(readoutConc), .readoutPercent(readoutPercent),
		.readoutBlank(readoutBlank), .cellFail(cellFail),
		.menuActive(menuActive));
	car_out_model u_car_out_model (.clk(clk), .relayEnergize(relayEnergize),
		.analogOut(analogOut), .contactMade(contactMade), .outPct(outPct));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// ========================================
	// report
	task automatic finish_test();
		#1;
		if (n_fail == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic note(input int k, input logic [31:0] v);
		expQ.push_back('{k, v});
		->chkEv;
	endtask

	always @(chkEv) begin
		while (expQ.size() > 0) begin
			curE = expQ.pop_front();
			case (curE.k)
			0: act = 32'(relayEnergize);
			1: act = 32'(analogOut.rangeId);
			2: act = 32'(analogOut.fullScale);
			3: act = 32'(analogOut.level);
			4: act = 32'(readoutConc);
			5: act = rdVal;
			6: act = 32'({readoutBlank, readoutPercent, cellFail, menuActive});
			7: act = 32'(contactMade);
			8: act = 32'(outPct);
			10: act = 32'(rdVal[9]);
			11: act = 32'(menuActive);
			12: act = 32'({hreadyout, hresp});
			default: act = tbVal;
			endcase
			n_compared++;
			if (act !== curE.v) begin
				n_fail++;
				$display("CHECK FAILED at %0t: kind %0d got %h expected %h",
					$time, curE.k, act, curE.v);
			end
		end
	end

	// ========================================
	// bus and sample drivers
	task automatic bus_wait();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'h1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			finish_test();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h00_0000, a};
		bus_wait();
		htrans <= 2'h0;
		hwdata <= d;
		bus_wait();
		rdVal = hrdata;
		// idle gap: a read right behind a write sees no forwarding
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		bus(1'h0, a, 32'h0000_0000);
		note(5, v);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic smp(input logic [17:0] c);
		@(posedge clk);
		sampleValid <= 1'h1;
		sampleConc  <= c;
		@(posedge clk);
		sampleValid <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
	endtask

	function automatic logic [31:0] cfg(input logic [3:0] f,
		input logic [17:0] sp);
		return {4'h0, f, 6'h00, sp};
	endfunction

	// ========================================
	// scenarios
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		finish_test();
	end

	initial begin
		hsel = 1'h1;
		hsize = 3'h2;
		htrans = 2'h0;
		hwrite = 1'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		sampleValid = 1'h0;
		sampleConc = 18'h0_0000;
		cellFailEvt = 1'h0;
		keyPin = 1'h0;
		sysRst = 1'h1;
		repeat (12) @(posedge clk);
		sysRst <= 1'h0;
		rd(OFS_RLOW, 32'h0000_0064);
		rd(OFS_RMID, 32'h0000_03e8);
		rd(OFS_RTOP, 32'h0000_2710);
		rd(8'h20, 32'h0000_0000);
		wr(OFS_AL1, cfg(4'h1, 18'h0_01f4));
		wr(OFS_AL2, cfg(4'h4, 18'h0_00c8));
		smp(18'h0_0258);
		note(0, 32'h0000_0003);
		note(7, 32'h0000_0003);
		note(12, 32'h0000_0002);
		smp(18'h0_01f4);
		note(0, 32'h0000_0002);
		smp(18'h0_0064);
		note(0, 32'h0000_0000);
		wr(OFS_AL1, cfg(4'h9, 18'h0_01f4));
		smp(18'h0_0258);
		smp(18'h0_012c);
		note(0, 32'h0000_0003);
		wr(OFS_AL1, cfg(4'h1, 18'h0_01f4));
		wr(OFS_AL1, cfg(4'h9, 18'h0_01f4));
		note(0, 32'h0000_0002);
		smp(18'h0_0258);
		smp(18'h0_012c);
		wr(OFS_AL1, cfg(4'hb, 18'h0_01f4));
		smp(18'h0_0258);
		note(0, 32'h0000_0002);
		smp(18'h0_012c);
		wr(OFS_AL1, cfg(4'h9, 18'h0_01f4));
		note(0, 32'h0000_0002);
		smp(18'h0_0032);
		note(1, 32'h0000_0000);
		note(2, 32'h0000_0064);
		smp(18'h0_4e20);
		note(1, 32'h0000_0001);
		smp(18'h0_4e20);
		note(1, 32'h0000_0002);
		note(2, 32'h0000_2710);
		note(6, 32'h0000_0004);
		smp(18'h0_0352);
		note(1, 32'h0000_0002);
		smp(18'h0_0351);
		note(1, 32'h0000_0001);
		for (int m = 1; m < 4; m++) begin
			wr(OFS_CTRL, 32'(m << CTRL_MODE));
			smp(18'h0_4e20);
			note(1, 32'(m - 1));
			note(3, 32'(m == 1 ? LOW_DEF : m == 2 ? MID_DEF : TOP_DEF));
			note(8, 32'h0000_0064);
		end
		wr(OFS_CTRL, CTRL_RST);
		wr(OFS_RMID, 32'h0000_0064);
		rd(OFS_RMID, 32'h0000_03e8);
		bus(1'h0, OFS_STATUS, 32'h0000_0000);
		note(10, 32'h0000_0001);
		wr(OFS_RTOP, 32'h0003_d090);
		rd(OFS_RTOP, 32'h0003_d090);
		bus(1'h0, OFS_STATUS, 32'h0000_0000);
		note(10, 32'h0000_0000);
		wr(OFS_RTOP, 32'h0000_2710);
		wr(OFS_CTRL, 32'h0000_0002);
		smp(18'h0_0064);
		note(1, 32'h0000_0003);
		note(2, 32'(AIR_FULL));
		wr(OFS_CTRL, CTRL_RST);
		smp(18'h0_4e20);
		@(posedge clk);
		cellFailEvt <= 1'h1;
		@(posedge clk);
		cellFailEvt <= 1'h0;
		wr(OFS_CTRL, 32'h0000_0001);
		note(6, 32'h0000_000a);
		note(0, 32'h0000_0000);
		note(3, 32'h0000_0000);
		note(4, 32'h0000_4e20);
		wr(OFS_CTRL, CTRL_RST);
		note(6, 32'h0000_0004);
		// back-to-back random samples, one every cycle
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rv = 18'($unsigned($random(seed)) % 32'h0003_d091);
			sampleValid <= 1'h1;
			sampleConc  <= rv;
			@(posedge clk);
		end
		sampleValid <= 1'h0;
		repeat (4) @(posedge clk);
		#1;
		note(4, 32'(rv));
		note(6, 32'({rv > PERCENT_ABOVE, 2'h0}));
		wr(OFS_CTRL, 32'h0000_0010);
		note(11, 32'h0000_0001);
		repeat (600) @(posedge clk);
		keyPin <= 1'h1;
		repeat (4) @(posedge clk);
		keyPin <= 1'h0;
		cnt = 0;
		while (menuActive === 1'h1 && cnt < 1400) begin
			@(posedge clk);
			cnt++;
		end
		// a key press restarts the full idle time of 1080 cycles
		tbVal = 32'(cnt > 1000 && cnt < 1200);
		note(9, 32'h0000_0001);
		finish_test();
	end
endmodule
`default_nettype wire
